// ### hdl/wdg_top.sv
/*
 wdg_top: watchdog supervisor with guard_control, status and mask registers.
 Assumes the core pulses instr_done once per completed instruction and
 that bus strobes are single-cycle and never both high at once.
*/
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
module wdg_top #(
	parameter int XTAL_UNIT = wdg_pkg::XTAL_PER_UNIT
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	// register port
	input wire wdg_pkg::wdg_bus_t bus,
	output logic [7:0] rdata,
	// core side
	input wire logic instr_done,
	input wire logic supply_monitor_irq,
	// crystal pin
	input wire logic xtal_in,
	// results
	output logic wdg_reset,
	output logic irq
);

	typedef struct packed {
		wdg_pkg::wdg_ctrl_t ctrl;
		wdg_pkg::wdg_unlock_t unl;
		logic [wdg_pkg::CNT_W-1:0] count;
		logic [wdg_pkg::ST_W-1:0] status;
		logic [wdg_pkg::ST_W-1:0] mask;
		logic [wdg_pkg::RCNT_W-1:0] rcnt;
		logic rst_out;
		logic irq;
		logic [7:0] rdata;
	} wdg_st_t;

	wdg_st_t s;
	wdg_st_t next_s;
	logic tick;
	logic wr_ctrl;
	logic applied;
	logic imm;
	logic valid_pre;
	logic expire;
	logic rst_mode;
	logic [wdg_pkg::ST_W-1:0] ev;
	logic [wdg_pkg::ST_W-1:0] w1c;

	// last count value before expiry for a prescale code
	function automatic logic [wdg_pkg::CNT_W-1:0] wdg_limit(input logic [3:0] pre);
		logic [wdg_pkg::CNT_W-1:0] len;
		len = wdg_pkg::CNT_W'(XTAL_UNIT) << pre[2:0];
		return len - wdg_pkg::CNT_W'(1);
	endfunction

	// true when a code is one that counts normally
	function automatic logic wdg_pre_ok(input logic [3:0] pre);
		return pre < wdg_pkg::PRE_IMMEDIATE;
	endfunction

	wdg_tick u_tick (
		.clock(clock),
		.rst(rst),
		.ce(ce),
		.xtal_in(xtal_in),
		.tick(tick)
	);

	assign wr_ctrl = bus.wr && (bus.addr == wdg_pkg::ADDR_CTRL);
	assign applied = wr_ctrl && (s.unl == wdg_pkg::UNL_OPEN);
	assign imm = s.ctrl.enable && (s.ctrl.prescale == wdg_pkg::PRE_IMMEDIATE);
	assign valid_pre = wdg_pre_ok(s.ctrl.prescale);
	assign expire = imm || (s.ctrl.enable && valid_pre && tick
		&& (s.count == wdg_limit(s.ctrl.prescale)));
	assign rst_mode = imm || !s.ctrl.select;

	always_comb
	begin
		ev = '0;
		ev[wdg_pkg::ST_TIMER] = expire && !rst_mode;
		ev[wdg_pkg::ST_RESET] = expire && rst_mode;
		ev[wdg_pkg::ST_BADPRE] = applied
			&& !wdg_pre_ok(bus.wdata[wdg_pkg::PRE_LSB+:4])
			&& (bus.wdata[wdg_pkg::PRE_LSB+:4] != wdg_pkg::PRE_IMMEDIATE);
		ev[wdg_pkg::ST_SUPPLY] = supply_monitor_irq;
		w1c = '0;
		if (bus.wr && (bus.addr == wdg_pkg::ADDR_STATUS))
			w1c = bus.wdata[wdg_pkg::ST_W-1:0];
	end

	always_comb
	begin
		next_s = s;

		// unlock sequencing
		case (s.unl)
			wdg_pkg::UNL_IDLE:
			begin
				if (wr_ctrl && bus.wdata[wdg_pkg::UNL_BIT])
					next_s.unl = instr_done ? wdg_pkg::UNL_OPEN : wdg_pkg::UNL_ARMED;
			end
			wdg_pkg::UNL_ARMED:
			begin
				if (instr_done)
					next_s.unl = wdg_pkg::UNL_OPEN;
			end
			wdg_pkg::UNL_OPEN:
			begin
				if (applied || instr_done)
					next_s.unl = wdg_pkg::UNL_IDLE;
				if (applied && bus.wdata[wdg_pkg::UNL_BIT])
					next_s.unl = instr_done ? wdg_pkg::UNL_OPEN : wdg_pkg::UNL_ARMED;
			end
			default:
				next_s.unl = wdg_pkg::UNL_IDLE;
		endcase

		// counting on crystal ticks
		if (s.ctrl.enable && valid_pre && tick)
			next_s.count = s.count + wdg_pkg::CNT_W'(1);

		// software update of guard_control
		if (applied)
		begin
			next_s.ctrl.prescale = bus.wdata[wdg_pkg::PRE_LSB+:4];
			next_s.ctrl.select = bus.wdata[wdg_pkg::SEL_BIT];
			next_s.ctrl.enable = bus.wdata[wdg_pkg::EN_BIT];
			if (!bus.wdata[wdg_pkg::FLAG_BIT])
				next_s.ctrl.flag = 1'b0;
			if (bus.wdata[wdg_pkg::EN_BIT])
				next_s.count = '0;
		end

		// expiry outcome
		if (expire)
		begin
			next_s.ctrl.flag = 1'b1;
			next_s.count = '0;
			if (rst_mode)
			begin
				next_s.ctrl.enable = 1'b0;
				next_s.rcnt = wdg_pkg::RCNT_W'(wdg_pkg::RST_PULSE_CYC);
			end
		end

		if (supply_monitor_irq)
			next_s.ctrl.enable = 1'b0;

		// reset pulse stretch
		if (!(expire && rst_mode) && (s.rcnt != '0))
			next_s.rcnt = s.rcnt - wdg_pkg::RCNT_W'(1);
		next_s.rst_out = (next_s.rcnt != '0);

		// sticky status, set beats clear
		next_s.status = (s.status & ~w1c) | ev;
		if (bus.wr && (bus.addr == wdg_pkg::ADDR_MASK))
			next_s.mask = bus.wdata[wdg_pkg::ST_W-1:0];
		next_s.irq = |(next_s.status & next_s.mask);

		// read port, unmapped reads zero
		next_s.rdata = 8'h00;
		if (bus.rd)
		begin
			case (bus.addr)
				wdg_pkg::ADDR_CTRL:
					next_s.rdata = {s.ctrl.prescale, s.ctrl.select, s.ctrl.flag,
						s.ctrl.enable, s.unl != wdg_pkg::UNL_IDLE};
				wdg_pkg::ADDR_STATUS:
					next_s.rdata = 8'(s.status);
				wdg_pkg::ADDR_MASK:
					next_s.rdata = 8'(s.mask);
				default:
					next_s.rdata = 8'h00;
			endcase
		end
	end

	// external reset clears flag and enable alike
	always_ff @(posedge clock)
	begin
		if (rst)
			s <= '0;
		else if (ce)
			s <= next_s;
	end

	assign rdata = s.rdata;
	assign wdg_reset = s.rst_out;
	assign irq = s.irq;

	// checks

	a_locked_write: assert property (@(posedge clock) disable iff (rst)
		(ce && wr_ctrl && s.unl == wdg_pkg::UNL_IDLE && !expire && !supply_monitor_irq)
		|=> (s.ctrl.prescale == $past(s.ctrl.prescale))
		&& (s.ctrl.enable == $past(s.ctrl.enable))
		&& (s.ctrl.select == $past(s.ctrl.select)))
		else $error("locked control write took effect");

	a_enable_restart: assert property (@(posedge clock) disable iff (rst)
		(ce && applied && bus.wdata[wdg_pkg::EN_BIT]
		&& !supply_monitor_irq && !(expire && rst_mode))
		|=> (s.count == '0) && s.ctrl.enable)
		else $error("enable write did not restart the count");

	a_flag_set: assert property (@(posedge clock) disable iff (rst)
		(ce && expire) |=> s.ctrl.flag)
		else $error("timeout flag not set on expiry");

	a_flag_hold: assert property (@(posedge clock) disable iff (rst)
		(s.ctrl.flag && !(ce && applied && !bus.wdata[wdg_pkg::FLAG_BIT]))
		|=> s.ctrl.flag)
		else $error("timeout flag dropped without a zero write");

	a_supply_clear: assert property (@(posedge clock) disable iff (rst)
		(ce && supply_monitor_irq) |=> !s.ctrl.enable)
		else $error("enable survived a supply monitor event");

	a_reset_pulse: assert property (@(posedge clock) disable iff (rst)
		(ce && expire && rst_mode) |=> wdg_reset && !s.ctrl.enable
		##1 (!ce || wdg_reset))
		else $error("reset mode expiry gave no reset pulse");

	a_timer_mode: assert property (@(posedge clock) disable iff (rst)
		(ce && expire && !rst_mode && !applied && !supply_monitor_irq)
		|=> s.status[wdg_pkg::ST_TIMER] && s.ctrl.enable && (s.count == '0))
		else $error("timer mode expiry lost its interrupt or enable");

	a_immediate: assert property (@(posedge clock) disable iff (rst)
		(ce && s.ctrl.enable && s.ctrl.prescale == wdg_pkg::PRE_IMMEDIATE)
		|=> wdg_reset)
		else $error("immediate code did not reset");

	a_reserved: assert property (@(posedge clock) disable iff (rst)
		(s.ctrl.prescale > wdg_pkg::PRE_IMMEDIATE) |-> !expire)
		else $error("reserved prescale code expired");

	a_count_bound: assert property (@(posedge clock) disable iff (rst)
		(s.ctrl.enable && valid_pre) |-> (s.count <= wdg_limit(s.ctrl.prescale)))
		else $error("count ran past the timeout period");

	a_unlock_drop: assert property (@(posedge clock) disable iff (rst)
		(ce && s.unl == wdg_pkg::UNL_OPEN && instr_done && !bus.wr)
		|=> s.unl == wdg_pkg::UNL_IDLE)
		else $error("unlock outlived the next instruction");

	// interrupt level is high once unmasked status rises
	a_irq_level: assert property (@(posedge clock) disable iff (rst)
		$rose(|(s.status & s.mask)) |-> irq)
		else $error("unmasked status without interrupt");

	a_unlock_open: assert property (@(posedge clock) disable iff (rst)
		(ce && s.unl == wdg_pkg::UNL_IDLE && wr_ctrl && bus.wdata[wdg_pkg::UNL_BIT] && instr_done)
		|=> s.unl == wdg_pkg::UNL_OPEN)
		else $error("unlock write did not open the control register");

	a_applied_write: assert property (@(posedge clock) disable iff (rst)
		(ce && applied && !expire && !supply_monitor_irq)
		|=> (s.ctrl.prescale == $past(bus.wdata[wdg_pkg::PRE_LSB+:4]))
		&& (s.ctrl.select == $past(bus.wdata[wdg_pkg::SEL_BIT]))
		&& (s.ctrl.enable == $past(bus.wdata[wdg_pkg::EN_BIT])))
		else $error("unlocked control write was lost");

	a_armed_wait: assert property (@(posedge clock) disable iff (rst)
		(ce && s.unl == wdg_pkg::UNL_ARMED && !instr_done)
		|=> s.unl == wdg_pkg::UNL_ARMED)
		else $error("unlock opened before its instruction completed");

	a_badpre_status: assert property (@(posedge clock) disable iff (rst)
		(ce && applied && (bus.wdata[wdg_pkg::PRE_LSB+:4] > wdg_pkg::PRE_IMMEDIATE))
		|=> s.status[wdg_pkg::ST_BADPRE])
		else $error("reserved prescale write not reported");

	a_immediate_clear: assert property (@(posedge clock) disable iff (rst)
		(ce && imm) |=> !s.ctrl.enable)
		else $error("immediate code left the watchdog enabled");

	a_reset_status: assert property (@(posedge clock) disable iff (rst)
		(ce && expire && rst_mode) |=> s.status[wdg_pkg::ST_RESET])
		else $error("watchdog reset not reported in status");

	a_pulse_start: assert property (@(posedge clock) disable iff (rst)
		(ce && expire && rst_mode) |=> s.rcnt == wdg_pkg::RCNT_W'(wdg_pkg::RST_PULSE_CYC))
		else $error("reset pulse did not load its full length");

	a_pulse_hold: assert property (@(posedge clock) disable iff (rst)
		(ce && s.rcnt > wdg_pkg::RCNT_W'(1)) |=> wdg_reset)
		else $error("reset pulse ended early");

	a_timer_quiet: assert property (@(posedge clock) disable iff (rst)
		(ce && expire && !rst_mode && s.rcnt == '0) |=> !wdg_reset)
		else $error("timer mode expiry raised a reset");

	a_supply_status: assert property (@(posedge clock) disable iff (rst)
		(ce && supply_monitor_irq) |=> s.status[wdg_pkg::ST_SUPPLY])
		else $error("supply monitor event not reported");

	a_irq_follows: assert property (@(posedge clock) disable iff (rst)
		irq == |(s.status & s.mask))
		else $error("interrupt level differs from unmasked status");

	a_ext_reset: assert property (@(posedge clock)
		rst |=> !s.ctrl.flag && !s.ctrl.enable && !wdg_reset)
		else $error("external reset left flag, enable or reset set");

	a_freeze: assert property (@(posedge clock) disable iff (rst)
		!ce |=> $stable(s))
		else $error("state moved while the clock enable was low");

endmodule // wdg_top

// ### hdl/wdg_pkg.sv
/*
 wdg_pkg: constants, register layout and carrier types of the watchdog block.
 Assumes a single 200 MHz core clock and a 32.768 kHz crystal level on a pin.
*/
//
// How it works
// - timeout is two to the prescale code times 512 crystal periods, 15.6 ms at code zero.
// - prescale code 1000b resets at once and codes above it are reserved and never expire.
// - the expiry interrupt ignores the global interrupt mask and has fixed high priority; here it reaches irq only while mask bit 0 is set.
// - with the select bit set the watchdog is a periodic timer that raises an interrupt.
// - every timeout sets the timeout flag at bit 2 of guard_control.
// - the flag clears only by a software zero write or external reset, not by its own reset.
// - setting the enable bit at bit 1 enables the watchdog and restarts its count.
// - if enable is not set again in time, a reset or interrupt follows as the select bit says.
// - enable clears on a zero write, own reset with select zero, external reset or supply monitor.
// - a guard_control write acts only if write_unlock (bit 0) was set by the previous instruction.
package wdg_pkg;

	// timing
	localparam int CLK_PERIOD_PS = 5000;
	localparam int RST_PULSE_NS = 100;
	localparam int RST_PULSE_CYC = (RST_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int XTAL_PER_UNIT = 512;
	localparam int CNT_W = 17;
	localparam int RCNT_W = 8;

	// register offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h01;
	localparam logic [7:0] ADDR_MASK = 8'h02;

	// guard_control fields
	localparam int PRE_LSB = 4;
	localparam int SEL_BIT = 3;
	localparam int FLAG_BIT = 2;
	localparam int EN_BIT = 1;
	localparam int UNL_BIT = 0;
	localparam logic [3:0] PRE_IMMEDIATE = 4'h8;

	// status and mask bits
	localparam int ST_TIMER = 0;
	localparam int ST_RESET = 1;
	localparam int ST_BADPRE = 2;
	localparam int ST_SUPPLY = 3;
	localparam int ST_W = 4;

	// values after reset
	localparam logic [3:0] PRE_RESET = 4'h0;
	localparam logic [ST_W-1:0] STATUS_RESET = 4'h0;
	localparam logic [ST_W-1:0] MASK_RESET = 4'h0;

	typedef enum logic [1:0] {UNL_IDLE, UNL_ARMED, UNL_OPEN} wdg_unlock_t;

	typedef struct packed {
		logic [3:0] prescale;
		logic select;
		logic flag;
		logic enable;
	} wdg_ctrl_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} wdg_bus_t;

endpackage

// ### hdl/wdg_tick.sv
/*
 wdg_tick: turns the asynchronous crystal level into one-cycle tick pulses.
 Assumes the crystal is far slower than the core clock.
*/
`timescale 1ns/1ps
module wdg_tick (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	// crystal pin
	input wire logic xtal_in,
	// one pulse per crystal rising edge
	output logic tick
);

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
		logic tick;
	} wdg_tick_st_t;

	wdg_tick_st_t s;
	wdg_tick_st_t next_s;

	always_comb
	begin
		next_s = s;
		next_s.s1 = xtal_in;
		next_s.s2 = s.s1;
		next_s.s3 = s.s2;
		next_s.tick = 1'b0;
		// a change counts only when the last two stages agree
		if (s.s2 == s.s3)
		begin
			next_s.lvl = s.s3;
			next_s.tick = s.s3 & ~s.lvl;
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			s <= '0;
		else if (ce)
			s <= next_s;
	end

	assign tick = s.tick;

endmodule // wdg_tick

// ### sim/watchdog_timer_control_tb.sv
/*
 watchdog_timer_control_tb: register-level tests of wdg_top.
 Assumes XTAL_UNIT shortened to 4 and a crystal of 16 core cycles.
*/
`timescale 1ns/1ps
module watchdog_timer_control_tb;
	logic clock = 0;
	logic rst = 1;
	logic ce = 1;
	logic instr_done = 0;
	logic supply_monitor_irq = 0;
	logic [3:0] xcnt = 4'h0;
	logic prev_rst_out = 0;
	int resets_seen = 0;
	int fail_count = 0;
	int samples_checked = 0;
	wdg_pkg::wdg_bus_t bus = '0;
	logic [7:0] rdata;
	logic wdg_reset;
	logic irq;
	wire xtal_in = xcnt[3];

	wdg_top #(.XTAL_UNIT(4)) wdg_top_i (
		.clock(clock),
		.rst(rst),
		.ce(ce),
		.bus(bus),
		.rdata(rdata),
		.instr_done(instr_done),
		.supply_monitor_irq(supply_monitor_irq),
		.xtal_in(xtal_in),
		.wdg_reset(wdg_reset),
		.irq(irq)
	);

	always #2.5 clock = ~clock;
	// crystal stand-in, free running
	always @(posedge clock) xcnt <= xcnt + 4'h1;
	always @(posedge clock)
	begin
		prev_rst_out <= wdg_reset;
		if (wdg_reset === 1'b1 && prev_rst_out !== 1'b1)
			resets_seen++;
	end

	task chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// every write is one completed instruction
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		instr_done <= 1'b1;
		@(posedge clock);
		bus.wr <= 1'b0;
		instr_done <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clock);
		bus.rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask

	task ctrl(input logic [7:0] d);
		wr(8'h00, 8'h01);
		wr(8'h00, d);
	endtask

	// sel 1 waits for wdg_reset, sel 0 for irq
	task wait_out(input bit sel);
		int n;
		n = 0;
		while ((sel ? wdg_reset : irq) !== 1'b1 && n < 600)
		begin
			@(posedge clock);
			#1;
			n++;
		end
		chk({7'h00, sel ? wdg_reset : irq}, 8'h01);
	endtask

	task wrap_up;
		$display("checks %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial
	begin
		#200000;
		fail_count++;
		wrap_up();
	end

	initial
	begin
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		rd(8'h00, 8'h00);
		rd(8'h01, 8'h00);
		rd(8'h02, 8'h00);
		rd(8'h05, 8'h00);
		wr(8'h00, 8'h72);
		rd(8'h00, 8'h00);
		wr(8'h00, 8'h01);
		@(posedge clock);
		instr_done <= 1'b1;
		@(posedge clock);
		instr_done <= 1'b0;
		wr(8'h00, 8'h72);
		rd(8'h00, 8'h00);
		// unlock whose instruction completes late
		@(posedge clock);
		bus <= '{addr: 8'h00, wdata: 8'h01, wr: 1'b1, rd: 1'b0};
		@(posedge clock);
		bus.wr <= 1'b0;
		rd(8'h00, 8'h01);
		@(posedge clock);
		instr_done <= 1'b1;
		@(posedge clock);
		instr_done <= 1'b0;
		wr(8'h00, 8'h0A);
		rd(8'h00, 8'h0A);
		// interrupt mode, periodic timer
		wr(8'h02, 8'h01);
		ctrl(8'h0A);
		rd(8'h00, 8'h0A);
		wait_out(1'b0);
		chk({7'h00, wdg_reset}, 8'h00);
		rd(8'h00, 8'h0E);
		rd(8'h01, 8'h01);
		ctrl(8'h00);
		rd(8'h00, 8'h00);
		wr(8'h01, 8'h0F);
		rd(8'h01, 8'h00);
		@(posedge clock);
		chk({7'h00, irq}, 8'h00);
		// reset mode; own reset leaves the flag
		wr(8'h02, 8'h02);
		ctrl(8'h02);
		repeat (40) @(posedge clock);
		chk({7'h00, wdg_reset}, 8'h00);
		wait_out(1'b1);
		repeat (25) @(posedge clock);
		rd(8'h00, 8'h04);
		rd(8'h01, 8'h02);
		chk({7'h00, irq}, 8'h01);
		ctrl(8'h00);
		wr(8'h01, 8'h0F);
		// kicks in time keep reset away
		resets_seen = 0;
		repeat (5)
		begin
			ctrl(8'h12);
			repeat (60) @(posedge clock);
		end
		ctrl(8'h00);
		chk(8'(resets_seen), 8'h00);
		// immediate code
		ctrl(8'h82);
		wait_out(1'b1);
		repeat (25) @(posedge clock);
		rd(8'h00, 8'h84);
		// reserved code never expires
		ctrl(8'h00);
		wr(8'h01, 8'h0F);
		resets_seen = 0;
		ctrl(8'h92);
		repeat (300) @(posedge clock);
		chk(8'(resets_seen), 8'h00);
		rd(8'h01, 8'h04);
		ctrl(8'h00);
		wr(8'h01, 8'h0F);
		// supply monitor drops enable
		ctrl(8'h02);
		@(posedge clock);
		supply_monitor_irq <= 1'b1;
		@(posedge clock);
		supply_monitor_irq <= 1'b0;
		rd(8'h00, 8'h00);
		rd(8'h01, 8'h08);
		// external reset clears the flag
		ctrl(8'h82);
		wait_out(1'b1);
		@(posedge clock);
		rst <= 1'b1;
		@(posedge clock);
		rst <= 1'b0;
		rd(8'h00, 8'h00);
		// low clock enable holds the count
		resets_seen = 0;
		ctrl(8'h02);
		@(posedge clock);
		ce <= 1'b0;
		repeat (100) @(posedge clock);
		ce <= 1'b1;
		chk(8'(resets_seen), 8'h00);
		rd(8'h00, 8'h02);
		wait_out(1'b1);
		wrap_up();
	end
endmodule // watchdog_timer_control_tb
